/* File: design/bpc_prim_reset.sv */
// Primary clock and reset behaviour of the bridge core.
// Assumes the primary bus pins are synchronous to clk_in; pin tristating
// is resolved outside from the enables.
`default_nettype none

// Behaviour
// [RULE1] All primary timing from one primary clock
// [RULE2] Sample primary signals on rising clock edge
// [RULE3] Primary outputs float while reset asserted
// [RULE4] Reset returns all registers to reset value; the hs_pipe enable sync in bpc_sync has no reset
// [RULE5] No response or initiation during reset
// [RULE6] Secondary interface driven low during reset
// [RULE7] Hot-swap indicator high in reset when enabled
// [RULE8] After release, start from default state
module bpc_prim_reset (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic hot_swap_enable_in,
   input wire bpc_pkg::bpc_pri_bus_t pri_bus_in,
   output logic [31:0] pri_ad_out,
   output logic pri_ad_oe_out,
   output logic [31:0] sec_ad_out,
   output logic sec_ad_oe_out,
   output logic hot_swap_indicator_out,
   output logic hot_swap_indicator_oe_out,
   output logic running_out
);

   // ------------------------------------------------------------------
   // Reset and strap synchronisation
   // ------------------------------------------------------------------
   // Release is held two edges so every flop of the core state st leaves reset on one edge
   logic primary_reset_level;
   logic hs_en;

   bpc_sync u_sync (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .hs_en_in(hot_swap_enable_in),
      .rst_out(primary_reset_level),
      .hs_en_out(hs_en)
   );

   // ------------------------------------------------------------------
   // Core state
   // ------------------------------------------------------------------
   bpc_pkg::bpc_core_t st;
   bpc_pkg::bpc_core_t next_st;
   logic run;
   logic hit_cfg;
   logic hit_fwd;

   assign run = (st.state == bpc_pkg::BPC_ST_RUN) && !primary_reset_level;
   assign hit_cfg = st.samp_ok && !st.samp.frame_n && st.samp.idsel;
   assign hit_fwd = st.samp_ok && !st.samp.frame_n && !st.samp.idsel;

   always_comb
   begin
      next_st = st;
      case (st.state)
         bpc_pkg::BPC_ST_RESET:
         begin
            // Held here with every field at its reset value
            next_st = bpc_pkg::CORE_RESET; // RULE4
            if (!primary_reset_level)
            begin
               next_st.state = bpc_pkg::BPC_ST_RUN; // RULE8
               // Release the secondary pins rather than keep them low
               next_st.sec.oe = 1'b0;
            end
         end
         bpc_pkg::BPC_ST_RUN:
         begin
            // Pins are captured only at the clock edge
            next_st.samp = pri_bus_in; // RULE2
            next_st.samp_ok = 1'b1;
            // Selected frame: answer with a status word for one cycle
            next_st.pri.oe = hit_cfg;
            next_st.pri.ad = hit_cfg ?
               {{(bpc_pkg::AD_W - bpc_pkg::CNT_W - 1){1'b0}},
                st.frames, hs_en} : bpc_pkg::AD_ZERO;
            // Other frames pass to the secondary side
            next_st.sec.oe = hit_fwd;
            next_st.sec.ad = hit_fwd ? st.samp.ad : bpc_pkg::AD_ZERO;
            // Counter wraps at its 8-bit width; the whole count is reported
            if (hit_fwd || hit_cfg)
            begin
               next_st.frames = st.frames + bpc_pkg::CNT_ONE;
            end
         end
         default:
         begin
            next_st = bpc_pkg::CORE_RESET;
         end
      endcase
      // Reset overrides any bus activity at once
      if (primary_reset_level)
      begin
         next_st = bpc_pkg::CORE_RESET; // RULE5
      end
   end

   // Single primary clock times all transactions
   always_ff @(posedge clk_in or negedge nrst_in) // RULE1
   begin
      if (!nrst_in)
      begin
         st <= bpc_pkg::CORE_RESET; // RULE4
      end
      else
      begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Primary enable is a flop with reset value 0, so it floats at once
   assign pri_ad_out = st.pri.ad;
   assign pri_ad_oe_out = st.pri.oe; // RULE3
   assign sec_ad_out = st.sec.ad; // RULE6
   assign sec_ad_oe_out = st.sec.oe; // RULE6
   // The indicator floats unless the state is BPC_ST_RESET with hot-swap enabled
   assign hot_swap_indicator_oe_out =
      (st.state == bpc_pkg::BPC_ST_RESET) && hs_en; // RULE7
   assign hot_swap_indicator_out = hot_swap_indicator_oe_out; // RULE7
   assign running_out = st.state == bpc_pkg::BPC_ST_RUN;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   // Cycles with the pin low are masked by disable iff; the checks below
   // reach the two release edges, where the sync still holds reset
   logic in_rst;
   assign in_rst = st.state == bpc_pkg::BPC_ST_RESET;

   AST_PRI_FLOAT: // RULE3
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      primary_reset_level |=> !pri_ad_oe_out)
   else $error("primary driven during reset");

   AST_SEC_LOW: // RULE6
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      primary_reset_level |=> (sec_ad_oe_out &&
      sec_ad_out == bpc_pkg::AD_ZERO))
   else $error("secondary not driven low during reset");

   AST_SEC_RELEASE: // RULE6
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (run && !hit_fwd) |=> !sec_ad_oe_out)
   else $error("secondary driven outside reset and frames");

   AST_HS_HIGH: // RULE7
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      primary_reset_level |=> (hot_swap_indicator_oe_out == hs_en &&
      hot_swap_indicator_out == hs_en))
   else $error("hot-swap indicator not driven high");

   AST_HS_QUIET: // RULE7
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!primary_reset_level ##1 !primary_reset_level) |->
      !hot_swap_indicator_oe_out)
   else $error("hot-swap indicator driven outside reset");

   AST_RUN_CLEAN: // RULE5
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      primary_reset_level |-> (!running_out && !pri_ad_oe_out))
   else $error("core running while reset held");

   AST_NO_FUNC: // RULE5
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      primary_reset_level |=> (!pri_ad_oe_out && in_rst) ##1
      !pri_ad_oe_out)
   else $error("bus activity during reset");

   AST_REGS_CLEAR: // RULE4
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      primary_reset_level |=> (st.frames == bpc_pkg::CNT_ZERO &&
      !st.samp_ok))
   else $error("register not at reset value");

   AST_FRAME_COUNT: // RULE2
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (run && (hit_cfg || hit_fwd)) |=>
      (st.frames == $past(st.frames) + bpc_pkg::CNT_ONE))
   else $error("frame counter did not advance by one");

   AST_START_DEFAULT: // RULE8
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      $fell(primary_reset_level) |-> in_rst ##1
      (running_out && !sec_ad_oe_out && st.frames == bpc_pkg::CNT_ZERO))
   else $error("not started from default state");

   AST_RESPOND: // RULE2
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (run && !pri_bus_in.frame_n && pri_bus_in.idsel) ##1 run |=>
      (pri_ad_oe_out && pri_ad_out[0] == hs_en))
   else $error("selected frame not answered two edges later");

   AST_FORWARD: // RULE1
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (run && !pri_bus_in.frame_n && !pri_bus_in.idsel) ##1 run |=>
      (sec_ad_oe_out && sec_ad_out == $past(pri_bus_in.ad, 2)))
   else $error("frame not forwarded two edges later");

   COV_RELEASE:
   cover property (@(posedge clk_in) disable iff (!nrst_in)
      $fell(primary_reset_level) ##1 running_out);

   COV_RESPOND:
   cover property (@(posedge clk_in) disable iff (!nrst_in)
      run ##1 pri_ad_oe_out);

   COV_FORWARD:
   cover property (@(posedge clk_in) disable iff (!nrst_in)
      run ##1 (running_out && sec_ad_oe_out));

   COV_HS:
   cover property (@(posedge clk_in) disable iff (!nrst_in)
      hot_swap_indicator_out);

   COV_ANSWER_THEN_FORWARD:
   cover property (@(posedge clk_in) disable iff (!nrst_in)
      pri_ad_oe_out ##1 sec_ad_oe_out);

endmodule : bpc_prim_reset

`default_nettype wire

/* File: design/bpc_pkg.sv */
// Shared types and constants for the primary clock and reset block.
// Assumes one primary bus clock; all primary pins are synchronous to it.
`default_nettype none

package bpc_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int unsigned AD_W = 32;
   localparam int unsigned CNT_W = 8;

   // ------------------------------------------------------------------
   // States and reset values
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      BPC_ST_RESET = 2'b00,
      BPC_ST_RUN = 2'b01
   } bpc_state_t;

   localparam logic [AD_W-1:0] AD_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [1:0] SYNC_RST_ON = 2'b11;

   // Primary bus sample: address/data, frame (low active), select
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic frame_n;
      logic idsel;
   } bpc_pri_bus_t;

   // Driven pin group: value and output enable
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic oe;
   } bpc_drive_t;

   typedef struct packed {
      bpc_state_t state;
      bpc_pri_bus_t samp;
      logic samp_ok;
      bpc_drive_t pri;
      bpc_drive_t sec;
      logic [CNT_W-1:0] frames;
   } bpc_core_t;

   // Secondary side drives low during reset; primary floats
   localparam bpc_core_t CORE_RESET = '{
      state: BPC_ST_RESET,
      samp: '{ad: AD_ZERO, frame_n: 1'b1, idsel: 1'b0},
      samp_ok: 1'b0,
      pri: '{ad: AD_ZERO, oe: 1'b0},
      sec: '{ad: AD_ZERO, oe: 1'b1},
      frames: CNT_ZERO
   };

endpackage : bpc_pkg

`default_nettype wire

/* File: design/bpc_sync.sv */
// Reset release synchroniser and hot-swap enable level synchroniser.
// Assumes nrst_in is asynchronous; the enable pin is a slow static level.
`default_nettype none

module bpc_sync (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic hs_en_in,
   output logic rst_out,
   output logic hs_en_out
);

   // ------------------------------------------------------------------
   // Reset: asserts at once, releases after two clean edges
   // ------------------------------------------------------------------
   logic [1:0] rst_pipe;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_pipe <= bpc_pkg::SYNC_RST_ON;
      end
      else
      begin
         rst_pipe <= {rst_pipe[0], 1'b0};
      end
   end

   assign rst_out = rst_pipe[1];

   // ------------------------------------------------------------------
   // Enable level: no reset, so it stays valid while reset is held
   // ------------------------------------------------------------------
   logic [1:0] hs_pipe;

   always_ff @(posedge clk_in)
   begin
      hs_pipe <= {hs_pipe[0], hs_en_in};
   end

   assign hs_en_out = hs_pipe[1];

endmodule : bpc_sync

`default_nettype wire

/* File: bench/bpc_host_model.sv */
// Host bus agent model: presents frames on the primary bus.
// Assumes the bench changes its request inputs at the falling edge.
`default_nettype none

module bpc_host_model (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic sel_in,
   input wire logic [31:0] ad_in,
   output var bpc_pkg::bpc_pri_bus_t pri_bus_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------
   // Bus driver
   // ---------------------------------------------------------------
   initial pri_bus_out = '{ad: 32'h0, frame_n: 1'b1, idsel: 1'b0};

   // Idle data toggles so a stale sample never matches by luck
   always @(negedge clk_in)
   begin
      pri_bus_out.frame_n <= ~req_in;
      pri_bus_out.idsel <= req_in & sel_in;
      pri_bus_out.ad <= req_in ? ad_in : ~pri_bus_out.ad;
   end
endmodule : bpc_host_model

`default_nettype wire

/* File: bench/bpc_prim_reset_test.sv */
// Self-checking bench for the primary clock and reset block.
// Assumes the host model presents frames; expectations are local.
`default_nettype none

module bpc_prim_reset_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_in, nrst_in, hs_en, req, sel, pri_oe, sec_oe, ind, ind_oe, run;
   logic [31:0] ad, pri_ad, sec_ad;
   logic [7:0] frames;
   logic [33:0] h [3];
   bpc_pkg::bpc_pri_bus_t bus;
   int n_errors, samples_checked;

   // ---------------------------------------------------------------
   // Instances
   // ---------------------------------------------------------------
   bpc_host_model host (.clk_in(clk_in), .req_in(req), .sel_in(sel),
      .ad_in(ad), .pri_bus_out(bus));
   bpc_prim_reset DUT (.clk_in(clk_in), .nrst_in(nrst_in),
      .hot_swap_enable_in(hs_en), .pri_bus_in(bus), .pri_ad_out(pri_ad),
      .pri_ad_oe_out(pri_oe), .sec_ad_out(sec_ad), .sec_ad_oe_out(sec_oe),
      .hot_swap_indicator_out(ind), .hot_swap_indicator_oe_out(ind_oe),
      .running_out(run));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task chk(input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task give_verdict;
      if (n_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   // Reset held five cycles, so the strap sync has settled
   task do_reset(input logic hs);
      @(negedge clk_in);
      nrst_in = 1'b0;
      hs_en = hs;
      frames = 8'h00;
      repeat (5) @(negedge clk_in);
      chk({pri_oe, pri_ad}, 33'h0);
      chk(run, 1'b0);
      chk({sec_oe, sec_ad}, {1'b1, 32'h0});
      chk({ind, ind_oe}, {hs, hs});
      nrst_in = 1'b1;
      req <= 1'b0;
      @(negedge clk_in);
      @(negedge clk_in);
      chk(run, 1'b0);
      @(negedge clk_in);
      chk({run, sec_oe, ind_oe}, 3'b100);
   endtask : do_reset

   // Each stimulus shows at the outputs three falling edges later
   task run_frames(input int n);
      h = '{34'h0, 34'h0, 34'h0};
      for (int i = 0; i < n + 3; i++)
      begin
         @(negedge clk_in);
         chk({run, ind_oe}, 2'b10);
         chk(pri_oe, h[2][33] & h[2][32]);
         if (h[2][33] & h[2][32])
            chk(pri_ad, {23'h0, frames, hs_en});
         chk(sec_oe, h[2][33] & ~h[2][32]);
         if (h[2][33] & ~h[2][32])
            chk(sec_ad, h[2][31:0]);
         if (h[2][33])
            frames++;
         h[2] = h[1];
         h[1] = h[0];
         h[0][33] = i < n && (i < 4 || $urandom % 4 != 0);
         h[0][32] = i < 2 || (i > 3 && $urandom % 2 == 1);
         h[0][31:0] = (i == 2) ? 32'hffff_ffff : 32'($urandom);
         {req, sel, ad} <= h[0];
      end
   endtask : run_frames

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   initial
   begin
      nrst_in = 1'b0;
      hs_en = 1'b0;
      {req, sel, ad} = 34'h0;
      n_errors = 0;
      samples_checked = 0;
      frames = 8'h00;
      void'($urandom(21));
      do_reset(1'b1);
      run_frames(400);
      // Reset lands with a select frame held on the bus
      @(negedge clk_in);
      req <= 1'b1;
      sel <= 1'b1;
      repeat (3) @(negedge clk_in);
      nrst_in = 1'b0;
      #1;
      chk({pri_oe, sec_oe, sec_ad, run}, {2'b01, 33'h0});
      do_reset(1'b0);
      run_frames(20);
      give_verdict();
   end
endmodule : bpc_prim_reset_test

`default_nettype wire
